//--- pkg/freq_limit_pkg.sv
package freq_limit_pkg;

  // Frequencies are in units of 0.1 Hz
  localparam int FREQ_W = 16;
  typedef logic [FREQ_W-1:0] freq_t;

  localparam freq_t MAX_FREQ_RST   = 16'h04B0;
  localparam freq_t MAX_FREQ_TOP   = 16'h04B0;
  localparam freq_t MIN_FREQ_RST   = 16'h0000;
  localparam freq_t HS_MAX_RST     = 16'h04B0;
  localparam freq_t HS_MAX_LOW     = 16'h04B0;
  localparam freq_t HS_MAX_TOP     = 16'h0FA0;
  localparam freq_t JOG_FREQ_RST   = 16'h0032;
  localparam freq_t START_FREQ_RST = 16'h0005;
  localparam freq_t JUMP_OFF       = 16'h270F;
  localparam freq_t JUMP_TOP       = 16'h0FA0;
  localparam freq_t STALL_FLOOR    = 16'h000A;
  localparam freq_t ACCEL_STEP_RST = 16'h0001;
  localparam freq_t FREQ_ZERO      = 16'h0000;

  // Stall selection codes and column bits
  localparam logic [7:0] SEL_RST        = 8'h00;
  localparam logic [7:0] SEL_TABLE_TOP  = 8'h1F;
  localparam logic [7:0] SEL_DRIVE_ALL  = 8'h64;
  localparam logic [7:0] SEL_DRIVE_NFRL = 8'h65;
  localparam int SEL_FRL_OFF_BIT = 0;
  localparam int SEL_ACC_OFF_BIT = 1;
  localparam int SEL_CST_OFF_BIT = 2;
  localparam int SEL_DEC_OFF_BIT = 3;
  localparam int SEL_STOP_BIT    = 4;

  typedef struct packed {
    logic frl_en;
    logic acc_en;
    logic cst_en;
    logic dec_en;
    logic ol_stop;
  } stall_cfg_s;

  typedef enum {ST_IDLE, ST_RUN, ST_TRIP} run_state_e;

  // Timing
  localparam int CLK_PERIOD_NS    = 5;
  localparam int TICK_NS          = 1000000;
  localparam int TICK_CYCLES      = TICK_NS / CLK_PERIOD_NS;
  localparam int STALL_TIMEOUT_MS = 3000;
  localparam int TICK_MS          = 1;
  localparam int TIMEOUT_TICKS    = STALL_TIMEOUT_MS / TICK_MS;

  // AHB-Lite
  localparam int         HTRANS_ACT_BIT = 1;
  localparam logic [2:0] HSIZE_WORD     = 3'h2;

  // Register byte offsets
  localparam logic [7:0] OFS_MAX_FREQ   = 8'h00;
  localparam logic [7:0] OFS_MIN_FREQ   = 8'h04;
  localparam logic [7:0] OFS_HS_MAX     = 8'h08;
  localparam logic [7:0] OFS_JOG_FREQ   = 8'h0C;
  localparam logic [7:0] OFS_START_FREQ = 8'h10;
  localparam logic [7:0] OFS_JUMP_BASE  = 8'h14;
  localparam logic [7:0] OFS_JUMP_PITCH = 8'h08;
  localparam logic [7:0] OFS_JUMP_B     = 8'h04;
  localparam logic [7:0] OFS_STALL_SEL  = 8'h2C;
  localparam logic [7:0] OFS_EXT_DISP   = 8'h30;
  localparam logic [7:0] OFS_ACCEL_STEP = 8'h34;
  localparam logic [7:0] OFS_CTRL       = 8'h38;
  localparam logic [7:0] OFS_STATUS     = 8'h3C;
  localparam logic [7:0] OFS_INT_STAT   = 8'h40;
  localparam logic [7:0] OFS_INT_MASK   = 8'h44;

  localparam int CTRL_FAULT_CLR_BIT = 0;
  localparam int STAT_RUN_BIT       = 0;
  localparam int STAT_OVL_BIT       = 1;
  localparam int STAT_TMO_BIT       = 2;
  localparam int STAT_STOP_BIT      = 3;
  localparam int STAT_FREQ_LSB      = 16;

  localparam int INT_W        = 3;
  localparam int INT_OVL_BIT  = 0;
  localparam int INT_TMO_BIT  = 1;
  localparam int INT_STOP_BIT = 2;

endpackage : freq_limit_pkg

//--- sim/freq_source_model.sv
`timescale 1ns/100ps
module freq_source_model (
  input  wire logic                  i_clk,
  input  wire logic                  i_heavy,
  input  wire logic                  i_surge,
  input  wire freq_limit_pkg::freq_t i_out_freq,
  output logic                       o_stall_req = 1'b0,
  output logic                       o_frl_act = 1'b0
);
  import freq_limit_pkg::*;
  // Current passes stall level only while turning under heavy load
  always @(posedge i_clk) begin
    o_stall_req <= i_heavy && (i_out_freq != FREQ_ZERO);
    o_frl_act   <= i_surge;
  end
endmodule : freq_source_model

//--- sim/output_frequency_limiter_props.sv
`timescale 1ns/100ps
module output_frequency_limiter_props #(
  parameter int TICK_CYC  = 4,
  parameter int TMO_TICKS = 5
) (
  input wire logic                       I_SYS_CLK,
  input wire logic                       I_RST_N,
  input wire logic                       I_STALL_REQ,
  input wire logic                       O_HREADYOUT,
  input wire logic                       O_HRESP,
  input wire freq_limit_pkg::freq_t      O_TARGET_FREQ,
  input wire freq_limit_pkg::freq_t      O_OUT_FREQ,
  input wire freq_limit_pkg::stall_cfg_s O_STALL_CFG,
  input wire logic                       O_OVERLOAD,
  input wire logic                       O_OUTPUT_STOP,
  input wire logic                       O_STALL_TIMEOUT_FAULT,
  input wire logic                       O_STALL_STOP_FAULT
);
  import freq_limit_pkg::*;
  localparam int DWELL_MIN = (TMO_TICKS - 1) * TICK_CYC;
  int floor_cnt;

  // Cycles spent at the stall floor
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      floor_cnt <= 0;
    end else if (O_OUT_FREQ == STALL_FLOOR) begin
      floor_cnt <= floor_cnt + 1;
    end else begin
      floor_cnt <= 0;
    end
  end

  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RST_N);

  sequence trip_entry;
    $rose(O_OUTPUT_STOP);
  endsequence
  sequence stop_cause;
    $past(I_STALL_REQ) && $past(O_STALL_CFG.ol_stop);
  endsequence

  bus_okay_a: assert property (O_HREADYOUT && !O_HRESP)
    else $error("bus answer not ready or not okay");
  tgt_ceiling_a: assert property (O_TARGET_FREQ <= HS_MAX_TOP)
    else $error("target above high-speed ceiling");
  ovl_cause_a: assert property ($rose(O_OVERLOAD) |-> $past(I_STALL_REQ))
    else $error("overload without stall request");
  ovl_enable_a: assert property (O_OVERLOAD |->
    $past(O_STALL_CFG.acc_en || O_STALL_CFG.cst_en || O_STALL_CFG.dec_en))
    else $error("overload with stall disabled");
  stop_trip_a: assert property (O_STALL_STOP_FAULT |-> O_OUTPUT_STOP)
    else $error("stop fault without output stop");
  stop_cause_a: assert property ($rose(O_STALL_STOP_FAULT) |-> stop_cause)
    else $error("stop fault without stop selection");
  trip_zero_a: assert property (trip_entry |=> O_OUT_FREQ == FREQ_ZERO)
    else $error("output not zero after trip");
  tmo_dwell_a: assert property ($rose(O_STALL_TIMEOUT_FAULT) |->
    floor_cnt >= DWELL_MIN && O_OUTPUT_STOP)
    else $error("timeout fault without floor dwell");
endmodule : output_frequency_limiter_props

//--- sim/output_frequency_limiter_tb.sv
`timescale 1ns/100ps
module output_frequency_limiter_tb;
  import freq_limit_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = HSIZE_WORD;
  logic        hready, hresp, stall_req, frl_act, overload, out_stop, tmo_f, stop_f, irq;
  logic        cmd_valid = 1'b0, start = 1'b0, jog = 1'b0, regen = 1'b0;
  logic        heavy = 1'b0, surge = 1'b0;
  freq_t       cmd_freq = '0, target, out_freq;
  stall_cfg_s  cfg;
  int          checked = 0, bad_count = 0, n;
  freq_t       jv[6] = '{16'h0258, 16'h0190, 16'h02BC, 16'h0320, 16'h0514, 16'h044C};
  freq_t       zc[3] = '{16'h01F4, 16'h02EE, 16'h047E};
  freq_t       ze[3] = '{16'h0258, 16'h02BC, 16'h04B0};
  logic [7:0]  sel_t[7] = '{8'h00, 8'h05, 8'h10, 8'h1F, 8'h64, 8'h64, 8'h65};
  logic [4:0]  cfg_t[7] = '{5'h1E, 5'h0A, 5'h1F, 5'h01, 5'h1E, 5'h00, 5'h0E};
  logic [6:0]  rg_t = 7'h20;

  always #2.5 clk = ~clk;

  output_frequency_limiter #(.TICK_CYC(4), .TMO_TICKS(5)) u_dut (
    .I_SYS_CLK(clk), .I_RST_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata),
    .I_HREADY(hready), .O_HREADYOUT(hready), .O_HRESP(hresp), .O_HRDATA(hrdata),
    .I_CMD_FREQ(cmd_freq), .I_CMD_VALID(cmd_valid), .I_START(start), .I_JOG(jog),
    .I_REGEN(regen), .I_STALL_REQ(stall_req), .I_FRL_ACT(frl_act),
    .O_TARGET_FREQ(target), .O_OUT_FREQ(out_freq), .O_STALL_CFG(cfg),
    .O_OVERLOAD(overload), .O_OUTPUT_STOP(out_stop), .O_STALL_TIMEOUT_FAULT(tmo_f),
    .O_STALL_STOP_FAULT(stop_f), .O_IRQ(irq));

  freq_source_model u_load (.i_clk(clk), .i_heavy(heavy), .i_surge(surge),
    .i_out_freq(out_freq), .o_stall_req(stall_req), .o_frl_act(frl_act));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One single AHB-Lite transfer, address phase then data phase
  task automatic bus(input logic [7:0] a, input logic w, input freq_t d);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0, d};
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input freq_t d);
    bus(a, 1'b1, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input freq_t e);
    bus(a, 1'b0, '0);
    chk(r, {16'h0, e});
  endtask : rd_chk

  task automatic setc(input freq_t f, input logic v);
    @(posedge clk);
    cmd_freq  <= f;
    cmd_valid <= v;
    repeat (4) @(negedge clk);
  endtask : setc

  task automatic quiet(input logic h, input logic s);
    @(posedge clk);
    heavy <= h;
    surge <= s;
    n = 0;
    repeat (40) begin
      @(negedge clk);
      if (overload !== 1'b0) n++;
    end
    @(posedge clk);
    heavy <= 1'b0;
    surge <= 1'b0;
    chk(n, 0);
  endtask : quiet

  task wrap_up;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #100000;
    bad_count++;
    $display("BAD t=%0t watchdog expired", $time);
    wrap_up;
  end

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(OFS_MAX_FREQ, MAX_FREQ_RST);
    rd_chk(OFS_MIN_FREQ, MIN_FREQ_RST);
    rd_chk(OFS_HS_MAX, HS_MAX_RST);
    for (int i = 0; i < 6; i++) rd_chk(OFS_JUMP_BASE + 8'(4 * i), JUMP_OFF);
    wr(8'h80, 16'h1234);
    rd_chk(8'h80, 16'h0000);
    setc(16'h0514, 1'b1);
    chk(32'(target), 32'(MAX_FREQ_RST));
    wr(OFS_MAX_FREQ, 16'h03E8);
    rd_chk(OFS_HS_MAX, 16'h03E8);
    wr(OFS_HS_MAX, 16'h0BB8);
    rd_chk(OFS_MAX_FREQ, 16'h0BB8);
    setc(16'h0DAC, 1'b1);
    chk(32'(target), 32'h0BB8);
    wr(OFS_MAX_FREQ, MAX_FREQ_TOP);
    wr(OFS_EXT_DISP, 16'h0001);
    wr(OFS_HS_MAX, 16'h07D0);
    rd_chk(OFS_HS_MAX, MAX_FREQ_TOP);
    wr(OFS_JUMP_BASE, 16'h01F4);
    rd_chk(OFS_JUMP_BASE, JUMP_OFF);
    wr(OFS_EXT_DISP, 16'h0000);
    wr(OFS_MIN_FREQ, 16'h012C);
    setc(16'h0064, 1'b1);
    chk(32'(target), 32'h012C);
    @(posedge clk);
    jog <= 1'b1;
    setc(16'h0064, 1'b1);
    chk(32'(target), 32'(JOG_FREQ_RST));
    @(posedge clk);
    jog <= 1'b0;
    for (int i = 0; i < 6; i++) wr(OFS_JUMP_BASE + 8'(4 * i), jv[i]);
    for (int i = 0; i < 3; i++) begin
      setc(zc[i], 1'b1);
      chk(32'(target), 32'(ze[i]));
    end
    wr(OFS_ACCEL_STEP, 16'h000A);
    wr(OFS_INT_MASK, 16'h0002);
    setc(16'h0000, 1'b0);
    @(posedge clk);
    start <= 1'b1;
    for (n = 0; n < 400 && out_freq !== 16'h012C; n++) @(negedge clk);
    chk(32'(out_freq), 32'h012C);
    @(posedge clk);
    heavy <= 1'b1;
    for (n = 0; n < 50 && overload !== 1'b1; n++) @(negedge clk);
    chk(32'(overload), 32'h1);
    for (n = 0; n < 400 && out_freq !== STALL_FLOOR; n++) @(negedge clk);
    chk(32'(out_freq), 32'(STALL_FLOOR));
    for (n = 0; n < 200 && tmo_f !== 1'b1; n++) @(negedge clk);
    chk(32'(tmo_f), 32'h1);
    chk(32'(out_stop), 32'h1);
    chk(32'(irq), 32'h1);
    @(posedge clk);
    heavy <= 1'b0;
    bus(OFS_INT_STAT, 1'b0, '0);
    chk(r, 32'h3);
    wr(OFS_INT_STAT, 16'h0003);
    @(negedge clk);
    chk(32'(irq), 32'h0);
    wr(OFS_CTRL, 16'h0001);
    @(negedge clk);
    chk(32'(tmo_f), 32'h0);
    chk(32'(out_stop), 32'h0);
    quiet(1'b0, 1'b1);
    for (int j = 0; j < 7; j++) begin
      wr(OFS_STALL_SEL, 16'(sel_t[j]));
      regen <= rg_t[j];
      setc(16'h0000, 1'b0);
      chk(32'(cfg), 32'(cfg_t[j]));
    end
    wr(OFS_STALL_SEL, 16'h000E);
    quiet(1'b1, 1'b1);
    chk(32'(tmo_f), 32'h0);
    wr(OFS_STALL_SEL, 16'h0010);
    heavy <= 1'b1;
    for (n = 0; n < 100 && stop_f !== 1'b1; n++) @(negedge clk);
    chk(32'(stop_f), 32'h1);
    chk(32'(out_stop), 32'h1);
    @(posedge clk);
    heavy <= 1'b0;
    bus(OFS_STATUS, 1'b0, '0);
    chk(32'(r[STAT_STOP_BIT]), 32'h1);
    wrap_up;
  end
endmodule : output_frequency_limiter_tb

bind output_frequency_limiter output_frequency_limiter_props #(
  .TICK_CYC (TICK_CYC),
  .TMO_TICKS(TMO_TICKS)
) u_props (
  .I_SYS_CLK            (I_SYS_CLK),
  .I_RST_N              (I_RST_N),
  .I_STALL_REQ          (I_STALL_REQ),
  .O_HREADYOUT          (O_HREADYOUT),
  .O_HRESP              (O_HRESP),
  .O_TARGET_FREQ        (O_TARGET_FREQ),
  .O_OUT_FREQ           (O_OUT_FREQ),
  .O_STALL_CFG          (O_STALL_CFG),
  .O_OVERLOAD           (O_OVERLOAD),
  .O_OUTPUT_STOP        (O_OUTPUT_STOP),
  .O_STALL_TIMEOUT_FAULT(O_STALL_TIMEOUT_FAULT),
  .O_STALL_STOP_FAULT   (O_STALL_STOP_FAULT)
);

//--- src/output_frequency_limiter.sv
// Chosen here: the AHB-Lite register port and the register offsets.
`timescale 1ns/100ps

// Summary of operation
// - Clamp output to maximum, reset 120 Hz
// - Hold output at minimum, reset 0 Hz
// - High-speed maximum 120-400 Hz is upper limit
// - Maximum and high-speed maximum writes copy across
// - Jog at or below minimum passes unclamped
// - Stall reduction may fall below minimum
// - Start alone ramps to minimum if valid
// - Three jump zones, 9999 disables, resets 9999
// - Zone edges taken in either order
// - Command inside zone runs at A point
// - Codes 100/101 split driving and regeneration
// - All-stall-off codes never signal overload
// - Stop-on-overload trips with stop fault
// - Fast current limit alone gives no overload
// - High-speed and jump writes need display zero
// - Selection columns decode enables and stop
// - Stall held at 1 Hz 3 s trips
module output_frequency_limiter #(
  parameter int TICK_CYC   = freq_limit_pkg::TICK_CYCLES,
  parameter int TMO_TICKS  = freq_limit_pkg::TIMEOUT_TICKS,
  parameter int JUMP_ZONES = 3
) (
  input  wire logic                       I_SYS_CLK,
  input  wire logic                       I_RST_N,
  input  wire logic                       I_HSEL,
  input  wire logic [31:0]                I_HADDR,
  input  wire logic [1:0]                 I_HTRANS,
  input  wire logic                       I_HWRITE,
  input  wire logic [2:0]                 I_HSIZE,
  input  wire logic [31:0]                I_HWDATA,
  input  wire logic                       I_HREADY,
  output logic                            O_HREADYOUT,
  output logic                            O_HRESP,
  output logic [31:0]                     O_HRDATA,
  input  wire freq_limit_pkg::freq_t      I_CMD_FREQ,
  input  wire logic                       I_CMD_VALID,
  input  wire logic                       I_START,
  input  wire logic                       I_JOG,
  input  wire logic                       I_REGEN,
  input  wire logic                       I_STALL_REQ,
  input  wire logic                       I_FRL_ACT,
  output freq_limit_pkg::freq_t           O_TARGET_FREQ,
  output freq_limit_pkg::freq_t           O_OUT_FREQ,
  output freq_limit_pkg::stall_cfg_s      O_STALL_CFG,
  output logic                            O_OVERLOAD,
  output logic                            O_OUTPUT_STOP,
  output logic                            O_STALL_TIMEOUT_FAULT,
  output logic                            O_STALL_STOP_FAULT,
  output logic                            O_IRQ
);
  import freq_limit_pkg::*;

  // Pin synchronisers: start, jog, regeneration
  logic [2:0]  pin_meta;
  logic [2:0]  pin_sync;
  logic        start_s;
  logic        jog_s;
  logic        regen_s;

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
    end else begin
      pin_meta <= {I_REGEN, I_JOG, I_START};
      pin_sync <= pin_meta;
    end
  end

  assign start_s = pin_sync[0];
  assign jog_s   = pin_sync[1];
  assign regen_s = pin_sync[2];

  // Settings
  freq_t       max_freq_setting;
  freq_t       min_freq_setting;
  freq_t       high_speed_max_freq_setting;
  freq_t       jog_freq_setting;
  freq_t       starting_freq_setting;
  freq_t       accel_step;
  freq_t       jump_a [JUMP_ZONES];
  freq_t       jump_b [JUMP_ZONES];
  logic [7:0]  stall_selection;
  logic [7:0]  extended_display_select;
  logic [INT_W-1:0] int_stat;
  logic [INT_W-1:0] int_mask;

  // Bus slave: zero wait states, always OKAY
  logic        acc;
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic        we;
  freq_t       wd;
  logic        ext_open;
  logic [31:0] rd_mux;
  logic        fault_clr;
  logic [INT_W-1:0] int_clr;

  assign acc = I_HSEL & I_HTRANS[HTRANS_ACT_BIT] & I_HREADY & (I_HSIZE == HSIZE_WORD);
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP     = 1'b0;
  assign we       = wr_pend;
  assign wd       = I_HWDATA[FREQ_W-1:0];
  assign ext_open = (extended_display_select == 8'h00);

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= acc & I_HWRITE;
      if (acc) begin
        wr_addr <= I_HADDR[7:0];
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_HRDATA <= 32'h0000_0000;
    end else if (acc && !I_HWRITE) begin
      O_HRDATA <= rd_mux;
    end
  end

  // Linked limits
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      max_freq_setting            <= MAX_FREQ_RST;
      high_speed_max_freq_setting <= HS_MAX_RST;
    end else if (we && wr_addr == OFS_MAX_FREQ && wd <= MAX_FREQ_TOP) begin
      max_freq_setting            <= wd;
      high_speed_max_freq_setting <= wd;
    end else if (we && wr_addr == OFS_HS_MAX && ext_open
                 && wd >= HS_MAX_LOW && wd <= HS_MAX_TOP) begin
      high_speed_max_freq_setting <= wd;
      max_freq_setting            <= wd;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      min_freq_setting        <= MIN_FREQ_RST;
      jog_freq_setting        <= JOG_FREQ_RST;
      starting_freq_setting   <= START_FREQ_RST;
      accel_step              <= ACCEL_STEP_RST;
      stall_selection         <= SEL_RST;
      extended_display_select <= 8'h00;
    end else if (we) begin
      case (wr_addr)
        OFS_MIN_FREQ: begin
          if (wd <= MAX_FREQ_TOP) begin
            min_freq_setting <= wd;
          end
        end
        OFS_JOG_FREQ: begin
          if (wd <= HS_MAX_TOP) begin
            jog_freq_setting <= wd;
          end
        end
        OFS_START_FREQ: begin
          if (wd <= HS_MAX_TOP) begin
            starting_freq_setting <= wd;
          end
        end
        OFS_ACCEL_STEP: accel_step <= wd;
        OFS_STALL_SEL: begin
          if (wd[7:0] <= SEL_TABLE_TOP || wd[7:0] == SEL_DRIVE_ALL
              || wd[7:0] == SEL_DRIVE_NFRL) begin
            stall_selection <= wd[7:0];
          end
        end
        OFS_EXT_DISP: extended_display_select <= wd[7:0];
        default: ;
      endcase
    end
  end

  // Jump zones
  logic [JUMP_ZONES-1:0] zone_hit;
  freq_t                 cmd;

  assign cmd = I_CMD_VALID ? I_CMD_FREQ : FREQ_ZERO;

  genvar z;
  generate
    for (z = 0; z < JUMP_ZONES; z++) begin : g_zone
      localparam logic [7:0] OFS_A = 8'(OFS_JUMP_BASE + z * OFS_JUMP_PITCH);
      localparam logic [7:0] OFS_B = 8'(OFS_A + OFS_JUMP_B);
      freq_t lo;
      freq_t hi;

      always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
          jump_a[z] <= JUMP_OFF;
          jump_b[z] <= JUMP_OFF;
        end else if (we && ext_open && (wd <= JUMP_TOP || wd == JUMP_OFF)) begin
          if (wr_addr == OFS_A) begin
            jump_a[z] <= wd;
          end
          if (wr_addr == OFS_B) begin
            jump_b[z] <= wd;
          end
        end
      end

      assign lo = (jump_a[z] < jump_b[z]) ? jump_a[z] : jump_b[z];
      assign hi = (jump_a[z] < jump_b[z]) ? jump_b[z] : jump_a[z];
      assign zone_hit[z] = (jump_a[z] != JUMP_OFF) && (jump_b[z] != JUMP_OFF)
                           && cmd >= lo && cmd <= hi;
    end
  endgenerate

  // Limited target
  freq_t jumped;
  freq_t next_target;

  always_comb begin
    jumped = cmd;
    for (int i = JUMP_ZONES - 1; i >= 0; i--) begin
      if (zone_hit[i]) begin
        jumped = jump_a[i];
      end
    end
    if (jog_s) begin
      if (jog_freq_setting <= min_freq_setting) begin
        next_target = jog_freq_setting;
      end else if (jog_freq_setting > high_speed_max_freq_setting) begin
        next_target = high_speed_max_freq_setting;
      end else begin
        next_target = jog_freq_setting;
      end
    end else if (!I_CMD_VALID && min_freq_setting < starting_freq_setting) begin
      next_target = FREQ_ZERO;
    end else if (jumped > high_speed_max_freq_setting) begin
      next_target = high_speed_max_freq_setting;
    end else if (jumped < min_freq_setting) begin
      next_target = min_freq_setting;
    end else begin
      next_target = jumped;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_TARGET_FREQ <= FREQ_ZERO;
    end else begin
      O_TARGET_FREQ <= next_target;
    end
  end

  // Stall selection decode
  stall_cfg_s cfg;

  always_comb begin
    cfg = '0;
    if (stall_selection == SEL_DRIVE_ALL || stall_selection == SEL_DRIVE_NFRL) begin
      if (!regen_s) begin
        cfg.frl_en = (stall_selection == SEL_DRIVE_ALL);
        cfg.acc_en = 1'b1;
        cfg.cst_en = 1'b1;
        cfg.dec_en = 1'b1;
      end
    end else begin
      cfg.frl_en  = ~stall_selection[SEL_FRL_OFF_BIT];
      cfg.acc_en  = ~stall_selection[SEL_ACC_OFF_BIT];
      cfg.cst_en  = ~stall_selection[SEL_CST_OFF_BIT];
      cfg.dec_en  = ~stall_selection[SEL_DEC_OFF_BIT];
      cfg.ol_stop = stall_selection[SEL_STOP_BIT];
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_STALL_CFG <= '0;
    end else begin
      O_STALL_CFG <= cfg;
    end
  end

  // Run state and ramp
  run_state_e state;
  logic [31:0] tick_cnt;
  logic        tick;
  logic        run_req;
  logic        stall_on;
  logic [15:0] tmo_cnt;
  logic        tmo_ev;
  logic        stop_ev;
  logic        ovl_ev;
  logic [FREQ_W:0] up_sum;
  freq_t       next_out;

  assign tick    = (tick_cnt == 32'(TICK_CYC - 1));
  assign run_req = start_s | jog_s;

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      tick_cnt <= 32'h0000_0000;
    end else if (tick) begin
      tick_cnt <= 32'h0000_0000;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
    end
  end

  // Stall acts by phase; fast current limit never counts
  always_comb begin
    if (O_OUT_FREQ < O_TARGET_FREQ) begin
      stall_on = cfg.acc_en;
    end else if (O_OUT_FREQ > O_TARGET_FREQ) begin
      stall_on = cfg.dec_en;
    end else begin
      stall_on = cfg.cst_en;
    end
    stall_on = stall_on & I_STALL_REQ & (state == ST_RUN);
  end

  assign ovl_ev  = stall_on & ~O_OVERLOAD;
  assign stop_ev = stall_on & cfg.ol_stop;
  assign tmo_ev  = tick & stall_on & (O_OUT_FREQ <= STALL_FLOOR)
                   & (tmo_cnt == 16'(TMO_TICKS - 1));
  assign up_sum  = {1'b0, O_OUT_FREQ} + {1'b0, accel_step};

  always_comb begin
    next_out = O_OUT_FREQ;
    if (state == ST_TRIP) begin
      next_out = FREQ_ZERO;
    end else if (tick) begin
      if (stall_on) begin
        if (O_OUT_FREQ > STALL_FLOOR) begin
          if (O_OUT_FREQ - accel_step > STALL_FLOOR && O_OUT_FREQ > accel_step) begin
            next_out = O_OUT_FREQ - accel_step;
          end else begin
            next_out = STALL_FLOOR;
          end
        end
      end else if (!run_req || state != ST_RUN) begin
        next_out = (O_OUT_FREQ > accel_step) ? O_OUT_FREQ - accel_step : FREQ_ZERO;
      end else if (O_OUT_FREQ < O_TARGET_FREQ) begin
        next_out = (up_sum > {1'b0, O_TARGET_FREQ}) ? O_TARGET_FREQ
                                                    : up_sum[FREQ_W-1:0];
      end else if (O_OUT_FREQ > O_TARGET_FREQ) begin
        next_out = (O_OUT_FREQ - accel_step > O_TARGET_FREQ && O_OUT_FREQ > accel_step)
                   ? O_OUT_FREQ - accel_step : O_TARGET_FREQ;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_OUT_FREQ <= FREQ_ZERO;
    end else begin
      O_OUT_FREQ <= next_out;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      tmo_cnt <= 16'h0000;
    end else if (!stall_on || O_OUT_FREQ > STALL_FLOOR) begin
      tmo_cnt <= 16'h0000;
    end else if (tick) begin
      tmo_cnt <= tmo_cnt + 16'h0001;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_OVERLOAD <= 1'b0;
    end else begin
      O_OVERLOAD <= stall_on;
    end
  end

  assign fault_clr = we && wr_addr == OFS_CTRL && I_HWDATA[CTRL_FAULT_CLR_BIT];

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state                 <= ST_IDLE;
      O_STALL_TIMEOUT_FAULT <= 1'b0;
      O_STALL_STOP_FAULT    <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (run_req) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (tmo_ev) begin
            state                 <= ST_TRIP;
            O_STALL_TIMEOUT_FAULT <= 1'b1;
          end else if (stop_ev) begin
            state              <= ST_TRIP;
            O_STALL_STOP_FAULT <= 1'b1;
          end else if (!run_req && O_OUT_FREQ == FREQ_ZERO) begin
            state <= ST_IDLE;
          end
        end
        ST_TRIP: begin
          if (fault_clr) begin
            state                 <= ST_IDLE;
            O_STALL_TIMEOUT_FAULT <= 1'b0;
            O_STALL_STOP_FAULT    <= 1'b0;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  assign O_OUTPUT_STOP = (state == ST_TRIP);

  // Interrupts: sticky, write one to clear, set wins
  assign int_clr = (we && wr_addr == OFS_INT_STAT) ? I_HWDATA[INT_W-1:0] : '0;

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      int_stat <= '0;
      int_mask <= '0;
    end else begin
      int_stat <= (int_stat & ~int_clr) | {stop_ev & (state == ST_RUN) & ~tmo_ev,
                                           tmo_ev, ovl_ev};
      if (we && wr_addr == OFS_INT_MASK) begin
        int_mask <= I_HWDATA[INT_W-1:0];
      end
    end
  end

  assign O_IRQ = |(int_stat & int_mask);

  // Read mux
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (I_HADDR[7:0])
      OFS_MAX_FREQ:   rd_mux[FREQ_W-1:0] = max_freq_setting;
      OFS_MIN_FREQ:   rd_mux[FREQ_W-1:0] = min_freq_setting;
      OFS_HS_MAX:     rd_mux[FREQ_W-1:0] = high_speed_max_freq_setting;
      OFS_JOG_FREQ:   rd_mux[FREQ_W-1:0] = jog_freq_setting;
      OFS_START_FREQ: rd_mux[FREQ_W-1:0] = starting_freq_setting;
      OFS_STALL_SEL:  rd_mux[7:0]        = stall_selection;
      OFS_EXT_DISP:   rd_mux[7:0]        = extended_display_select;
      OFS_ACCEL_STEP: rd_mux[FREQ_W-1:0] = accel_step;
      OFS_STATUS: begin
        rd_mux[STAT_RUN_BIT]  = (state == ST_RUN);
        rd_mux[STAT_OVL_BIT]  = O_OVERLOAD;
        rd_mux[STAT_TMO_BIT]  = O_STALL_TIMEOUT_FAULT;
        rd_mux[STAT_STOP_BIT] = O_STALL_STOP_FAULT;
        rd_mux[STAT_FREQ_LSB +: FREQ_W] = O_OUT_FREQ;
      end
      OFS_INT_STAT:   rd_mux[INT_W-1:0] = int_stat;
      OFS_INT_MASK:   rd_mux[INT_W-1:0] = int_mask;
      default: begin
        for (int i = 0; i < JUMP_ZONES; i++) begin
          if (I_HADDR[7:0] == 8'(OFS_JUMP_BASE + i * OFS_JUMP_PITCH)) begin
            rd_mux[FREQ_W-1:0] = jump_a[i];
          end
          if (I_HADDR[7:0] == 8'(OFS_JUMP_BASE + i * OFS_JUMP_PITCH + OFS_JUMP_B)) begin
            rd_mux[FREQ_W-1:0] = jump_b[i];
          end
        end
      end
    endcase
  end

endmodule : output_frequency_limiter
